// ---- rtl/psb_device.sv ----
// psb_device: processor end of the system bus with its four-entry write buffer
// assumes: agent end follows the same handshakes; one clock, sync reset
// Function
// - 64-bit shared bus with 8 check bits
// - command marks address or data each cycle
// - command gives type or data attributes
// - command bus two-way, requests both directions
// - single 1-8 byte and 32-byte block transfers
// - size and block flag on command, full address on bus
// - agent readies sampled before address removed
// - external request answered by release, slave
// - processor request answered by agent grant
// - agent signals swapped order of two reads
// - swap strobe leads data by two cycles
// - read kind marks instruction reads
// - outbound valid exactly when driving valid
// - inbound valid only while agent owns bus
// - buffer four address/data pairs for writes
// - write-back fills the whole buffer
// - outgoing data rate from boot mode bits
// - agent paces inbound data, always accepted
// - read: address, then release if ready
// - at most two reads outstanding
`timescale 1ns/10ps
module psb_device
	import psb_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic [RATE_W-1:0] mode_wr_rate,
	input  wire logic              mode_multi_rd,
	psb_bus_if.dev                 bus,
	input  wire logic              wr_valid,
	output logic                   wr_ready,
	input  wire logic [AD_W-1:0]   wr_addr,
	input  wire logic [AD_W-1:0]   wr_data,
	input  wire logic [SZ_W-1:0]   wr_size,
	input  wire logic              wr_wback,
	input  wire logic              rd_valid,
	output logic                   rd_ready,
	input  wire logic [AD_W-1:0]   rd_addr,
	input  wire logic [SZ_W-1:0]   rd_size,
	input  wire logic              rd_block,
	input  wire logic              rd_instr,
	output logic                   rsp_valid,
	output logic [AD_W-1:0]        rsp_data,
	output logic                   rsp_last,
	output logic                   rsp_err,
	output logic                   rsp_second,
	output logic                   ext_wr_valid,
	output logic [AD_W-1:0]        ext_wr_addr,
	output logic [AD_W-1:0]        ext_wr_data
);
	typedef enum logic [2:0] {
		PSB_IDLE, PSB_ADDR, PSB_WDATA, PSB_WGAP, PSB_REL, PSB_SLAVE
	} psb_dst_t;
	psb_dst_t          st_q, st_d;
	logic [RATE_W-1:0] rate_q, gap_q, gap_d;
	logic              multi_q;
	logic [1:0]        out_q, out_d, beat_q, beat_d, wbl_q, wbl_d;
	logic              swap_q, swap_d, is_rd_q, is_rd_d, rinstr_q, rinstr_d;
	logic              rblk_q, rblk_d, xpend_q, xpend_d;
	logic [AD_W-1:0]   raddr_q, raddr_d, xaddr_d;
	logic [SZ_W-1:0]   rsize_q, rsize_d;
	logic              rv_d, rl_d, re_d, r2_d, xv_d;
	logic [AD_W-1:0]   rdat_d, xdat_d;
	logic              can_rd, issue, done, wlast, want, wb_pop;
	logic              wb_in_valid, wb_in_ready, wb_out_valid, wb_empty;
	psb_wb_entry_t     wb_in, wb_head;
	// ==========================================================
	// write buffer
	// a write-back is only started into an empty buffer and then owns all four slots
	assign wb_in = '{addr: wr_addr, data: wr_data, size: wr_size, blk: wr_wback};
	assign wr_ready = wb_in_ready && (wr_wback ? (wbl_q != '0 || wb_empty) : wbl_q == '0);
	assign wb_in_valid = wr_valid && wr_ready;
	psb_fifo #(
		.W     ($bits(psb_wb_entry_t)),
		.DEPTH (WB_DEPTH)
	) u_wbuf (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.in_valid  (wb_in_valid),
		.in_ready  (wb_in_ready),
		.in_data   (wb_in),
		.out_valid (wb_out_valid),
		.out_ready (wb_pop),
		.out_data  (wb_head),
		.empty     (wb_empty)
	);
	// ==========================================================
	// bus master / slave sequencing
	assign can_rd = multi_q ? (out_q < OUT_TWO) : (out_q < OUT_ONE);
	assign rd_ready = (st_q == PSB_IDLE) && bus.external_bus_request_n && can_rd;
	assign wlast = !wb_head.blk || beat_q == BEAT_LAST;
	assign want = (rd_valid && can_rd) || wb_out_valid;
	always_comb begin
		st_d = st_q;
		gap_d = gap_q;
		beat_d = beat_q;
		is_rd_d = is_rd_q;
		raddr_d = raddr_q;
		rsize_d = rsize_q;
		rblk_d = rblk_q;
		rinstr_d = rinstr_q;
		xpend_d = xpend_q;
		xaddr_d = ext_wr_addr;
		xdat_d = ext_wr_data;
		rdat_d = rsp_data;
		rl_d = rsp_last;
		re_d = rsp_err;
		r2_d = rsp_second;
		rv_d = 1'b0;
		xv_d = 1'b0;
		issue = 1'b0;
		done = 1'b0;
		wb_pop = 1'b0;
		unique case (st_q)
			PSB_IDLE: begin
				if (!bus.external_bus_request_n) begin
					st_d = PSB_REL;
				end else if (rd_valid && can_rd) begin
					is_rd_d = 1'b1;
					raddr_d = rd_addr;
					rsize_d = rd_size;
					rblk_d = rd_block;
					rinstr_d = rd_instr;
					st_d = PSB_ADDR;
				end else if (wb_out_valid) begin
					is_rd_d = 1'b0;
					st_d = PSB_ADDR;
				end
			end
			PSB_ADDR: begin
				// address stays on the bus until the matching ready is seen
				if (is_rd_q && !bus.read_accept_ready_n) begin
					issue = 1'b1;
					st_d = PSB_REL;
				end else if (!is_rd_q && !bus.write_accept_ready_n) begin
					st_d = PSB_WDATA;
				end
			end
			PSB_WDATA: begin
				// block data may still be loading; wait without a valid beat
				if (wb_out_valid) begin
					wb_pop = 1'b1;
					beat_d = beat_q + 1'b1;
					if (wlast) begin
						beat_d = '0;
						st_d = PSB_IDLE;
					end else if (rate_q != '0) begin
						gap_d = rate_q;
						st_d = PSB_WGAP;
					end
				end
			end
			PSB_WGAP: begin
				gap_d = gap_q - 1'b1;
				if (gap_q == RATE_W'(1)) st_d = PSB_WDATA;
			end
			PSB_REL: begin
				st_d = PSB_SLAVE;
			end
			PSB_SLAVE: begin
				if (!bus.processor_bus_grant_n) st_d = PSB_IDLE;
				if (!bus.inbound_valid_n) begin
					if (bus.cmd[CMD_ADDR_BIT]) begin
						if (psb_cmd_type(bus.cmd) == PSB_T_NULL) begin
							st_d = PSB_IDLE;
						end else if (psb_cmd_type(bus.cmd) == PSB_T_WRITE) begin
							xpend_d = 1'b1;
							xaddr_d = bus.ad;
						end
					end else if (xpend_q) begin
						xpend_d = 1'b0;
						xv_d = 1'b1;
						xdat_d = bus.ad;
					end else begin
						rv_d = 1'b1;
						rdat_d = bus.ad;
						rl_d = bus.cmd[CMD_LAST_BIT];
						re_d = bus.cmd[CMD_ERR_BIT] || psb_check(bus.ad) != bus.adc;
						r2_d = swap_q && out_q == OUT_TWO;
						done = bus.cmd[CMD_LAST_BIT];
					end
				end
			end
			default: st_d = PSB_IDLE;
		endcase
	end
	// outstanding reads, swap marker and write-back loading
	always_comb begin
		out_d = issue ? out_q + 1'b1 : (done ? out_q - 1'b1 : out_q);
		swap_d = !bus.response_order_swap_n || (swap_q && !done);
		wbl_d = wbl_q;
		if (wb_in_valid && wr_wback) wbl_d = (wbl_q == BEAT_LAST) ? '0 : wbl_q + 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			// boot mode bits are caught while reset is held
			rate_q <= mode_wr_rate;
			multi_q <= mode_multi_rd;
			st_q <= PSB_IDLE;
			gap_q <= '0;
			out_q <= '0;
			beat_q <= '0;
			wbl_q <= '0;
			swap_q <= 1'b0;
			is_rd_q <= 1'b0;
			rinstr_q <= 1'b0;
			rblk_q <= 1'b0;
			xpend_q <= 1'b0;
			raddr_q <= '0;
			rsize_q <= '0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rsp_last <= 1'b0;
			rsp_err <= 1'b0;
			rsp_second <= 1'b0;
			ext_wr_valid <= 1'b0;
			ext_wr_addr <= '0;
			ext_wr_data <= '0;
		end else begin
			st_q <= st_d;
			gap_q <= gap_d;
			out_q <= out_d;
			beat_q <= beat_d;
			wbl_q <= wbl_d;
			swap_q <= swap_d;
			is_rd_q <= is_rd_d;
			rinstr_q <= rinstr_d;
			rblk_q <= rblk_d;
			xpend_q <= xpend_d;
			raddr_q <= raddr_d;
			rsize_q <= rsize_d;
			rsp_valid <= rv_d;
			rsp_data <= rdat_d;
			rsp_last <= rl_d;
			rsp_err <= re_d;
			rsp_second <= r2_d;
			ext_wr_valid <= xv_d;
			ext_wr_addr <= xaddr_d;
			ext_wr_data <= xdat_d;
		end
	end
	// ==========================================================
	// pin drive
	assign bus.dev_oe = st_q inside {PSB_IDLE, PSB_ADDR, PSB_WDATA, PSB_WGAP};
	assign bus.ad_dev = (st_q != PSB_ADDR) ? wb_head.data :
		(is_rd_q ? raddr_q : wb_head.addr);
	assign bus.adc_dev = psb_check(bus.ad_dev);
	assign bus.cmd_dev = (st_q != PSB_ADDR) ? psb_data_cmd(wlast, 1'b0) :
		(is_rd_q ? psb_addr_cmd(PSB_T_READ, rblk_q, rsize_q)
		: psb_addr_cmd(PSB_T_WRITE, wb_head.blk, wb_head.size));
	assign bus.outbound_valid_n = !(st_q == PSB_ADDR || (st_q == PSB_WDATA && wb_out_valid));
	assign bus.read_kind = (st_q == PSB_ADDR) && is_rd_q && rinstr_q;
	assign bus.bus_release_n = (st_q != PSB_REL);
	assign bus.processor_bus_request_n = !(st_q == PSB_SLAVE && want);
endmodule // psb_device

// ---- inc/psb_pkg.sv ----
// psb_pkg: widths, command layout and helpers of the processor system bus
// assumes: imported whole by the interface and by both ends
package psb_pkg;
	// ==========================================================
	// bus widths and buffer depth
	localparam int AD_W     = 64;
	localparam int ADC_W    = 8;
	localparam int BYTE_W   = 8;
	localparam int CMD_W    = 9;
	localparam int SZ_W     = 3;
	localparam int TYPE_W   = 2;
	localparam int RATE_W   = 2;
	localparam int WB_DEPTH = 4;
	// ==========================================================
	// command bus layout
	localparam int CMD_ADDR_BIT = 8;
	localparam int CMD_TYPE_LSB = 6;
	localparam int CMD_LAST_BIT = 7;
	localparam int CMD_ERR_BIT  = 6;
	localparam logic       CMD_IS_ADDR = 1'h1;
	localparam logic       CMD_IS_DATA = 1'h0;
	localparam logic [1:0] CMD_PAD2    = 2'h0;
	localparam logic [5:0] CMD_PAD6    = 6'h00;
	localparam logic [2:0] SZ_FULL     = 3'h7; // eight bytes
	localparam logic [1:0] BEAT_LAST   = 2'h3; // fourth word of a block
	localparam logic [1:0] OUT_ONE     = 2'h1;
	localparam logic [1:0] OUT_TWO     = 2'h2;
	localparam int         SWAP_LEAD   = 2;
	localparam logic [1:0] SWAP_WAIT   = 2'(SWAP_LEAD - 1);
	typedef enum logic [TYPE_W-1:0] {PSB_T_READ, PSB_T_WRITE, PSB_T_NULL, PSB_T_RSV} psb_cmd_type_t;
	// one write buffer entry
	typedef struct packed {
		logic [AD_W-1:0] addr;
		logic [AD_W-1:0] data;
		logic [SZ_W-1:0] size;
		logic            blk;
	} psb_wb_entry_t;
	// ==========================================================
	// helpers shared by both ends
	function automatic logic [ADC_W-1:0] psb_check(input logic [AD_W-1:0] d);
		logic [ADC_W-1:0] c;
		c = '0;
		for (int i = 0; i < ADC_W; i++) begin
			c[i] = ^d[i*BYTE_W +: BYTE_W];
		end
		return c;
	endfunction
	function automatic logic [CMD_W-1:0] psb_addr_cmd(input psb_cmd_type_t t, input logic blk,
		input logic [SZ_W-1:0] sz);
		return {CMD_IS_ADDR, t, blk, CMD_PAD2, sz};
	endfunction
	function automatic logic [CMD_W-1:0] psb_data_cmd(input logic last, input logic err);
		return {CMD_IS_DATA, last, err, CMD_PAD6};
	endfunction
	function automatic psb_cmd_type_t psb_cmd_type(input logic [CMD_W-1:0] c);
		return psb_cmd_type_t'(c[CMD_TYPE_LSB +: TYPE_W]);
	endfunction
endpackage

// ---- inc/psb_bus_if.sv ----
// psb_bus_if: the system bus pins between processor end and external agent
// assumes: each end drives only its own half; shared buses resolve here
`timescale 1ns/10ps
interface psb_bus_if;
	import psb_pkg::*;
	logic [AD_W-1:0]  ad_dev, ad_agt, ad;
	logic [ADC_W-1:0] adc_dev, adc_agt, adc;
	logic [CMD_W-1:0] cmd_dev, cmd_agt, cmd;
	logic             dev_oe, agt_oe;
	logic             outbound_valid_n, read_kind, bus_release_n, processor_bus_request_n;
	logic             inbound_valid_n, read_accept_ready_n, write_accept_ready_n;
	logic             external_bus_request_n, processor_bus_grant_n, response_order_swap_n;
	// ==========================================================
	// wire level: the driving owner wins, an undriven bus reads zero
	assign ad  = dev_oe ? ad_dev : (agt_oe ? ad_agt : '0);
	assign adc = dev_oe ? adc_dev : (agt_oe ? adc_agt : '0);
	assign cmd = dev_oe ? cmd_dev : (agt_oe ? cmd_agt : '0);
	modport dev (
		input  ad, adc, cmd, inbound_valid_n, read_accept_ready_n, write_accept_ready_n,
		input  external_bus_request_n, processor_bus_grant_n, response_order_swap_n,
		output ad_dev, adc_dev, cmd_dev, dev_oe, outbound_valid_n, read_kind,
		output bus_release_n, processor_bus_request_n
	);
	modport agt (
		input  ad, adc, cmd, outbound_valid_n, read_kind, bus_release_n, processor_bus_request_n,
		output ad_agt, adc_agt, cmd_agt, agt_oe, inbound_valid_n, read_accept_ready_n,
		output write_accept_ready_n, external_bus_request_n, processor_bus_grant_n,
		output response_order_swap_n
	);
endinterface

// ---- rtl/psb_fifo.sv ----
// psb_fifo: flop-based fifo with valid/ready on both sides
// assumes: single clock, synchronous active-high reset
`timescale 1ns/10ps
module psb_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data,
	output logic              empty
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          push, pop;
	// wrap-around works for any depth, not only powers of two
	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction
	// ==========================================================
	// pointers and fill level
	always_comb begin
		push  = in_valid && in_ready;
		pop   = out_valid && out_ready;
		wr_d  = push ? nxt(wr_q) : wr_q;
		rd_d  = pop ? nxt(rd_q) : rd_q;
		cnt_d = (AW+1)'(cnt_q + push - pop);
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end
	// storage entries
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				mem_q[i] <= '0;
			end else if (push && wr_q == AW'(i)) begin
				mem_q[i] <= in_data;
			end
		end
	end
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH)); // honest full
	assign out_valid = (cnt_q != '0);
	assign empty     = (cnt_q == '0);
	assign out_data  = mem_q[rd_q];
endmodule // psb_fifo

// ---- rtl/psb_agent.sv ----
// psb_agent: external agent end of the system bus (memory/io controller side)
// assumes: user side supplies response data and external writes; one clock
`timescale 1ns/10ps
module psb_agent
	import psb_pkg::*;
(
	input  wire logic            ref_clk,
	input  wire logic            sys_rst,
	psb_bus_if.agt               bus,
	input  wire logic            rd_accept,
	input  wire logic            wr_accept,
	input  wire logic            take_bus,
	input  wire logic            give_back,
	output logic                 req_valid,
	output logic                 req_write,
	output logic [AD_W-1:0]      req_addr,
	output logic [SZ_W-1:0]      req_size,
	output logic                 req_block,
	output logic                 req_instr,
	output logic                 wdat_valid,
	output logic [AD_W-1:0]      wdat_data,
	output logic                 wdat_last,
	input  wire logic            rsp_valid,
	output logic                 rsp_ready,
	input  wire logic [AD_W-1:0] rsp_data,
	input  wire logic            rsp_last,
	input  wire logic            rsp_err,
	input  wire logic            rsp_swap,
	input  wire logic            ew_valid,
	output logic                 ew_ready,
	input  wire logic [AD_W-1:0] ew_addr,
	input  wire logic [AD_W-1:0] ew_data
);
	typedef enum logic [1:0] {AG_IDLE, AG_OWN, AG_SWAP, AG_EWD} psb_ast_t;
	psb_ast_t         st_q, st_d;
	logic [1:0]       cnt_q, cnt_d;
	logic             in_rsp_q, in_rsp_d, beat, null_now;
	logic [AD_W-1:0]  ad_q, ad_d;
	logic [CMD_W-1:0] cmd_q, cmd_d;
	logic             oe_q, oe_d, vld_n_q, vld_n_d, swp_n_q, swp_n_d, gnt_n_q, gnt_n_d;
	logic             xrq_n_q, xrq_n_d, rrdy_n_q, wrdy_n_q;
	logic             see_addr, see_data;
	// ==========================================================
	// ownership and driving decisions; bus pins are registered
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		in_rsp_d = in_rsp_q;
		ad_d = ad_q;
		cmd_d = cmd_q;
		vld_n_d = 1'b1;
		swp_n_d = 1'b1;
		gnt_n_d = 1'b1;
		beat = 1'b0;
		null_now = 1'b0;
		rsp_ready = 1'b0;
		ew_ready = 1'b0;
		unique case (st_q)
			AG_IDLE: begin
				if (!bus.bus_release_n) st_d = AG_OWN;
			end
			AG_OWN: begin
				if (!bus.processor_bus_request_n && !in_rsp_q) begin
					gnt_n_d = 1'b0;
					st_d = AG_IDLE;
				end else if (rsp_valid && rsp_swap && !in_rsp_q) begin
					swp_n_d = 1'b0;
					cnt_d = SWAP_WAIT;
					st_d = AG_SWAP;
				end else if (rsp_valid) begin
					beat = 1'b1;
				end else if (ew_valid) begin
					ad_d = ew_addr;
					cmd_d = psb_addr_cmd(PSB_T_WRITE, 1'b0, SZ_FULL);
					vld_n_d = 1'b0;
					st_d = AG_EWD;
				end else if (give_back) begin
					cmd_d = psb_addr_cmd(PSB_T_NULL, 1'b0, SZ_FULL);
					vld_n_d = 1'b0;
					null_now = 1'b1;
					st_d = AG_IDLE;
				end
			end
			AG_SWAP: begin
				// data follows the swap strobe two cycles later
				if (cnt_q == '0) begin
					beat = 1'b1;
					st_d = AG_OWN;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			AG_EWD: begin
				ew_ready = 1'b1;
				ad_d = ew_data;
				cmd_d = psb_data_cmd(1'b1, 1'b0);
				vld_n_d = 1'b0;
				st_d = AG_OWN;
			end
		endcase
		if (beat) begin
			rsp_ready = 1'b1;
			ad_d = rsp_data;
			cmd_d = psb_data_cmd(rsp_last, rsp_err);
			vld_n_d = 1'b0;
			in_rsp_d = !rsp_last;
		end
		oe_d = (st_d != AG_IDLE) || null_now;
		xrq_n_d = !(st_d == AG_IDLE && (take_bus || ew_valid));
	end
	// outbound frames seen while the processor owns the bus
	assign see_addr = !bus.outbound_valid_n && bus.cmd[CMD_ADDR_BIT];
	assign see_data = !bus.outbound_valid_n && !bus.cmd[CMD_ADDR_BIT];
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= AG_IDLE;
			cnt_q <= '0;
			in_rsp_q <= 1'b0;
			ad_q <= '0;
			cmd_q <= '0;
			oe_q <= 1'b0;
			vld_n_q <= 1'b1;
			swp_n_q <= 1'b1;
			gnt_n_q <= 1'b1;
			xrq_n_q <= 1'b1;
			rrdy_n_q <= 1'b1;
			wrdy_n_q <= 1'b1;
			req_valid <= 1'b0;
			req_write <= 1'b0;
			req_addr <= '0;
			req_size <= '0;
			req_block <= 1'b0;
			req_instr <= 1'b0;
			wdat_valid <= 1'b0;
			wdat_data <= '0;
			wdat_last <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			in_rsp_q <= in_rsp_d;
			ad_q <= ad_d;
			cmd_q <= cmd_d;
			oe_q <= oe_d;
			vld_n_q <= vld_n_d;
			swp_n_q <= swp_n_d;
			gnt_n_q <= gnt_n_d;
			xrq_n_q <= xrq_n_d;
			rrdy_n_q <= !rd_accept;
			wrdy_n_q <= !wr_accept;
			req_valid <= see_addr;
			req_write <= psb_cmd_type(bus.cmd) == PSB_T_WRITE;
			req_addr <= bus.ad;
			req_size <= bus.cmd[SZ_W-1:0];
			req_block <= bus.cmd[CMD_ADDR_BIT-3];
			req_instr <= bus.read_kind;
			wdat_valid <= see_data;
			wdat_data <= bus.ad;
			wdat_last <= bus.cmd[CMD_LAST_BIT];
		end
	end
	assign bus.ad_agt = ad_q;
	assign bus.adc_agt = psb_check(ad_q);
	assign bus.cmd_agt = cmd_q;
	assign bus.agt_oe = oe_q;
	assign bus.inbound_valid_n = vld_n_q;
	assign bus.response_order_swap_n = swp_n_q;
	assign bus.processor_bus_grant_n = gnt_n_q;
	assign bus.external_bus_request_n = xrq_n_q;
	assign bus.read_accept_ready_n = rrdy_n_q;
	assign bus.write_accept_ready_n = wrdy_n_q;
endmodule // psb_agent

// ---- tb/psb_chk_sva.sv ----
// psb_chk_sva: wire-level checks between the processor end and the agent end
// assumes: fed from the psb_bus_if signals by the bench top, one clock
`timescale 1ns/10ps
module psb_chk
	import psb_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             sys_rst,
	input wire logic [AD_W-1:0]  ad,
	input wire logic [ADC_W-1:0] adc,
	input wire logic [CMD_W-1:0] cmd,
	input wire logic             dev_oe,
	input wire logic             agt_oe,
	input wire logic             outbound_valid_n,
	input wire logic             read_kind,
	input wire logic             bus_release_n,
	input wire logic             inbound_valid_n,
	input wire logic             read_accept_ready_n,
	input wire logic             write_accept_ready_n,
	input wire logic             processor_bus_grant_n,
	input wire logic             response_order_swap_n
);
	// ==========
	// helpers
	logic [ADC_W-1:0] par;
	logic             addr_cyc;
	logic             rd_cyc;
	logic             wr_cyc;
	// even bit per byte, recomputed here rather than shared with the ends
	always_comb begin
		for (int i = 0; i < ADC_W; i++) begin
			par[i] = ^ad[i*BYTE_W +: BYTE_W];
		end
	end
	// address cycle decode from the command bus
	assign addr_cyc = !outbound_valid_n && cmd[CMD_ADDR_BIT];
	assign rd_cyc   = addr_cyc && cmd[CMD_TYPE_LSB +: TYPE_W] == 2'h0;
	assign wr_cyc   = addr_cyc && cmd[CMD_TYPE_LSB +: TYPE_W] == 2'h1;
	// ==========
	// properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_one_driver: assert property (!(dev_oe && agt_oe))
		else $error("both ends drive the bus");
	chk_valid_owner: assert property (!outbound_valid_n |-> dev_oe)
		else $error("outbound valid without drive");
	chk_agent_valid: assert property (!inbound_valid_n |-> agt_oe && !dev_oe)
		else $error("inbound valid without ownership");
	chk_check_bits: assert property (!(outbound_valid_n && inbound_valid_n) |-> adc == par)
		else $error("check bits disagree with bus");
	chk_read_kind: assert property (read_kind |-> rd_cyc)
		else $error("read kind outside read address");
	chk_read_release: assert property (rd_cyc && !read_accept_ready_n |=> !bus_release_n ##1 bus_release_n)
		else $error("read not followed by one release");
	chk_handover: assert property ($fell(bus_release_n) |-> !dev_oe ##1 (agt_oe && !dev_oe))
		else $error("release did not hand over");
	chk_write_hold: assert property (wr_cyc && write_accept_ready_n |=> addr_cyc && $stable(ad) && $stable(cmd))
		else $error("write address dropped while not ready");
	chk_grant_return: assert property (!processor_bus_grant_n |-> !agt_oe ##1 dev_oe)
		else $error("grant did not return the bus");
	chk_swap_lead: assert property ($fell(response_order_swap_n) |-> ##2 !inbound_valid_n)
		else $error("swap not two cycles ahead of data");
endmodule // psb_chk

// ---- tb/processor_system_bus_interface_test.sv ----
// processor_system_bus_interface_test: device and agent joined, tested from user ports
// assumes: package, interface, fifo, both ends and psb_chk compiled first
`timescale 1ns/10ps
module processor_system_bus_interface_test;
	import psb_pkg::*;
	logic            ref_clk, sys_rst, wr_valid, wr_ready, wr_wback, rd_valid, rd_ready;
	logic            rd_block, rd_instr, rsp_valid, rsp_last, rsp_err, rsp_second, ext_wr_valid;
	logic            rd_accept, wr_accept, take_bus, give_back, req_valid, req_write, req_block;
	logic            req_instr, wdat_valid, wdat_last, a_rsp_valid, a_rsp_ready, a_rsp_last;
	logic            a_rsp_err, a_rsp_swap, ew_valid, ew_ready;
	logic [SZ_W-1:0] wr_size, rd_size, req_size;
	logic [AD_W-1:0] wr_addr, wr_data, rd_addr, rsp_data, ext_wr_addr, ext_wr_data, req_addr;
	logic [AD_W-1:0] wdat_data, a_rsp_data, ew_addr, ew_data;
	int              num_errors = 0, checked = 0, n_acc = 0, n_wdat = 0, base, acc0;
	// ==========
	// the two ends and the checker
	psb_bus_if bus ();
	psb_device i_psb_device (.ref_clk, .sys_rst, .mode_wr_rate(2'h2), .mode_multi_rd(1'h1), .bus,
		.wr_valid, .wr_ready, .wr_addr, .wr_data, .wr_size, .wr_wback, .rd_valid, .rd_ready,
		.rd_addr, .rd_size, .rd_block, .rd_instr, .rsp_valid, .rsp_data, .rsp_last, .rsp_err,
		.rsp_second, .ext_wr_valid, .ext_wr_addr, .ext_wr_data);
	psb_agent i_psb_agent (.ref_clk, .sys_rst, .bus, .rd_accept, .wr_accept, .take_bus,
		.give_back, .req_valid, .req_write, .req_addr, .req_size, .req_block, .req_instr,
		.wdat_valid, .wdat_data, .wdat_last, .rsp_valid(a_rsp_valid), .rsp_ready(a_rsp_ready),
		.rsp_data(a_rsp_data), .rsp_last(a_rsp_last), .rsp_err(a_rsp_err), .rsp_swap(a_rsp_swap),
		.ew_valid, .ew_ready, .ew_addr, .ew_data);
	psb_chk i_psb_chk (.ref_clk, .sys_rst, .ad(bus.ad), .adc(bus.adc), .cmd(bus.cmd),
		.dev_oe(bus.dev_oe), .agt_oe(bus.agt_oe), .outbound_valid_n(bus.outbound_valid_n),
		.read_kind(bus.read_kind), .bus_release_n(bus.bus_release_n),
		.inbound_valid_n(bus.inbound_valid_n), .read_accept_ready_n(bus.read_accept_ready_n),
		.write_accept_ready_n(bus.write_accept_ready_n),
		.processor_bus_grant_n(bus.processor_bus_grant_n),
		.response_order_swap_n(bus.response_order_swap_n));
	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// tallies taken at the edge, before that edge's updates land
	always @(posedge ref_clk) begin
		if (wr_valid && wr_ready) n_acc++;
		if (wdat_valid) n_wdat++;
	end
	// ==========
	// tasks
	task automatic check(input logic [AD_W-1:0] seen, input logic [AD_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait, sampled at the falling edge where outputs are settled
	task automatic till(ref logic s);
		for (int n = 0; n < 300 && s !== 1'b1; n++) @(negedge ref_clk);
		if (s !== 1'b1) num_errors++;
	endtask
	task automatic wr(input logic [AD_W-1:0] a, d, input logic [SZ_W-1:0] s, input logic wb);
		@(negedge ref_clk);
		{wr_valid, wr_addr, wr_data, wr_size, wr_wback} = {1'b1, a, d, s, wb};
		#1;
		till(wr_ready);
		@(negedge ref_clk);
		wr_valid = 1'b0;
	endtask
	task automatic rd(input logic [AD_W-1:0] a, input logic ins);
		@(negedge ref_clk);
		{rd_valid, rd_addr, rd_size, rd_block, rd_instr} = {1'b1, a, SZ_FULL, 1'b0, ins};
		#1;
		till(rd_ready);
		@(negedge ref_clk);
		rd_valid = 1'b0;
	endtask
	// one-beat answer from the agent user side
	task automatic rsp(input logic [AD_W-1:0] d, input logic sw);
		@(negedge ref_clk);
		{a_rsp_valid, a_rsp_data, a_rsp_last, a_rsp_swap} = {1'b1, d, 1'b1, sw};
		#1;
		till(a_rsp_ready);
		@(negedge ref_clk);
		a_rsp_valid = 1'b0;
	endtask
	// release the stalled agent and wait for the beats
	task automatic drain(input int beats);
		wr_accept = 1'b1;
		for (int n = 0; n < 400 && n_wdat < base + beats; n++) @(negedge ref_clk);
	endtask
	task automatic final_report;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		final_report();
	end
	// ==========
	// main sequence
	initial begin
		{wr_valid, rd_valid, take_bus, give_back, a_rsp_valid, ew_valid} = 6'h00;
		{wr_wback, rd_block, rd_instr, a_rsp_last, a_rsp_err, a_rsp_swap} = 6'h00;
		{wr_addr, wr_data, wr_size, rd_addr, rd_size, a_rsp_data, ew_addr, ew_data} = '0;
		{rd_accept, wr_accept, sys_rst} = 3'h7;
		repeat (10) @(negedge ref_clk);
		sys_rst = 1'b0;
		wr(64'h1005, 64'hA5, 3'h2, 1'b0);
		till(req_valid);
		check(req_write, 1'b1);
		check(req_addr, 64'h1005);
		check(req_size, 3'h2);
		// stall the agent, push until refused, then drain all
		wr_accept = 1'b0;
		till(wdat_valid);
		@(negedge ref_clk);
		base = n_wdat;
		acc0 = n_acc;
		wr_valid = 1'b1;
		repeat (16) @(negedge ref_clk);
		check(wr_ready, 1'b0);
		check(64'(n_acc - acc0), 64'(WB_DEPTH));
		wr_valid = 1'b0;
		drain(n_acc - acc0);
		check(64'(n_wdat - base), 64'(n_acc - acc0));
		// write-back takes the whole buffer and leaves as one block
		wr_accept = 1'b0;
		base = n_wdat;
		for (int i = 0; i < WB_DEPTH; i++) begin
			wr(64'h2000, 64'(i), SZ_FULL, 1'b1);
			wr_wback = 1'b0;
			#1 check(wr_ready, 1'b0);
		end
		check(wr_ready, 1'b0);
		drain(4);
		check(64'(n_wdat - base), 64'h4);
		// external write while the agent holds the bus, then a null
		take_bus = 1'b1;
		@(negedge ref_clk);
		{ew_valid, ew_addr, ew_data} = {1'b1, 64'h80, 64'h5A5A};
		#1;
		till(ew_ready);
		@(negedge ref_clk);
		{ew_valid, take_bus} = 2'h0;
		till(ext_wr_valid);
		check(ext_wr_addr, 64'h80);
		check(ext_wr_data, 64'h5A5A);
		give_back = 1'b1;
		for (int n = 0; n < 300 && bus.dev_oe !== 1'b1; n++) @(negedge ref_clk);
		give_back = 1'b0;
		check(bus.dev_oe, 1'b1);
		rd(64'h3000, 1'b1);
		till(req_valid);
		check(req_write, 1'b0);
		check(req_instr, 1'b1);
		rsp(64'hCAFE_F00D, 1'b0);
		till(rsp_valid);
		check(rsp_data, 64'hCAFE_F00D);
		check(rsp_last, 1'b1);
		// two reads outstanding, the younger answered first
		rd(64'h4000, 1'b0);
		rd(64'h4020, 1'b0);
		rsp(64'h2222, 1'b1);
		till(rsp_valid);
		check(rsp_data, 64'h2222);
		check(rsp_second, 1'b1);
		rsp(64'h1111, 1'b0);
		till(rsp_valid);
		check(rsp_data, 64'h1111);
		check(rsp_second, 1'b0);
		final_report();
	end
endmodule // processor_system_bus_interface_test
